// file: rtl/reset_ctrl_pkg.sv
// Purpose: Shared constants and types for the system reset controller
// Assumes: 50 MHz ref_clk, one register word of 8 bits per address
// Notes: Delay and filter lengths are given as times and turned into cycles here
package reset_ctrl_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PIN_MIN_PULSE_NS = 400;
  localparam int BROWNOUT_MIN_PULSE_NS = 2000;
  localparam int RESET_DELAY_SHORT_US = 4;
  localparam int RESET_DELAY_LONG_US = 65;
  localparam int OSC_START_US = 1;
  // Least times round up to whole cycles
  localparam int PIN_FILTER_CYC = (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWNOUT_FILTER_CYC =
    (BROWNOUT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_DELAY_SHORT_CYC = (RESET_DELAY_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int RESET_DELAY_LONG_CYC = (RESET_DELAY_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int OSC_START_CYC = (OSC_START_US * 1000) / CLK_PERIOD_NS;
  localparam int DELAY_W = 16;
  localparam int FILTER_W = 8;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] RESET_CAUSE_FLAGS_ADDR = 2'h0;
  localparam logic [ADDR_W-1:0] RESET_LIVE_STATUS_ADDR = 2'h1;
  localparam logic [ADDR_W-1:0] FUSE_READBACK_ADDR = 2'h2;
  localparam logic [DATA_W-1:0] CAUSE_FLAGS_RESET = 8'h01;
  localparam logic [DATA_W-1:0] CAUSE_FLAGS_MASK = 8'h1F;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // Field positions of the cause flags
  localparam int POWERON_FLAG_BIT = 0;
  localparam int PIN_FLAG_BIT = 1;
  localparam int BROWNOUT_FLAG_BIT = 2;
  localparam int WATCHDOG_FLAG_BIT = 3;
  localparam int SCAN_FLAG_BIT = 4;

  // ==========================================================================
  // Fuse codes
  localparam logic [2:0] BROWNOUT_DISABLED = 3'h7;
  localparam logic [1:0] SUT_NO_DELAY = 2'h0;
  localparam logic [1:0] SUT_SHORT_DELAY = 2'h1;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic scan;
    logic watchdog;
    logic brownout;
    logic pin;
    logic poweron;
  } reset_sources_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic scan_reset_flag;
    logic watchdog_reset_flag;
    logic brownout_reset_flag;
    logic pin_reset_flag;
    logic poweron_reset_flag;
  } cause_flags_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } reset_state_t;

endpackage

// file: rtl/pulse_filter.sv
// Purpose: Passes a level only after it has stood for a given number of cycles
// Assumes: level_in synchronous to ref_clk
// Notes: Output drops at the first edge that samples the input low, one edge after the input drops
`timescale 1ns/1ps
module pulse_filter #(
  parameter int CNT_W = 8,
  parameter int COUNT = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic level_in,
  output logic level_out
);

  logic [CNT_W-1:0] count_reg;

  // ==========================================================================
  // Width counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      level_out <= 1'b0;
    end else if (!enable || !level_in) begin
      count_reg <= '0;
      level_out <= 1'b0;
    end else if (count_reg >= CNT_W'(COUNT - 1)) begin
      level_out <= 1'b1;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

endmodule // pulse_filter

// file: rtl/system_reset_controller.sv
// Purpose: Gathers reset sources, holds ports, stretches internal reset, logs cause
// Assumes: Detector levels and fuses synchronous to ref_clk, fuses static
// Notes: Asynchronous sources reach the hold flops through their async set path
// What this block does
// - Peripheral reset held while active; release pulses a fetch from the reset vector.
// - Port pins reset asynchronously the moment power-on, pin or scan becomes active; watchdog and brown-out at the next edge.
// - Delay counter stretches internal reset by a fuse-chosen time-out.
// - Exactly five sources: power-on, pin, watchdog, brown-out, scan register.
// - Pin low beyond the minimum width resets even without a clock.
// - Pin rising starts the delay counter; release after the time-out.
// - Power-on reasserts at once on low supply; rise starts the delay.
// - Reset held as long as the scan reset register holds one.
// - Watchdog gives a one-cycle pulse; delay starts on its falling edge.
// - Brown-out level fuse: 111 off, 110-100 reserved, 011-000 rising levels.
// - Enabled brown-out resets once it outlasts the minimum width; recovery starts the delay counter.
// - Supply dips shorter than the brown-out minimum width are ignored.
// - Scan flag bit 4 set by scan reset; cleared by power-on or zero write.
// - Watchdog flag bit 3 set by watchdog reset; cleared by power-on or zero.
// - Brown-out flag bit 2 set by brown-out; cleared by power-on or zero.
// - Pin flag bit 1 set by pin reset; cleared by power-on or zero write.
// - Power-on flag bit 0 set by power-on; only a zero write clears it.
`timescale 1ns/1ps
module system_reset_controller
  import reset_ctrl_pkg::*;
#(
  parameter int DELAY_SHORT_CYC = RESET_DELAY_SHORT_CYC,
  parameter int DELAY_LONG_CYC = RESET_DELAY_LONG_CYC,
  parameter int OSC_CYC = OSC_START_CYC,
  parameter int PIN_CYC = PIN_FILTER_CYC,
  parameter int BROWNOUT_CYC = BROWNOUT_FILTER_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic supply_below_poweron,
  input wire logic reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic supply_below_brownout,
  input wire logic scan_reset_bit,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  output logic port_reset,
  output logic periph_reset_n,
  output logic vector_fetch,
  output logic brownout_enable,
  output logic [1:0] brownout_trip_level
);

  // ==========================================================================
  // Source gathering
  logic async_hold_n;
  logic brownout_on;
  logic brownout_seen;
  logic pin_seen;
  logic watchdog_seen_reg;
  logic watchdog_pulse_reg;
  logic any_active;
  reset_sources_t sources;

  // Level fuse decode
  // Reserved codes are taken as disabled so an odd fuse never trips the part
  assign brownout_on = (brownout_level_fuses[2] == 1'b0);

  // Power-on, pin and scan bit holds
  // Gated with no clock, so a stopped oscillator cannot mask a reset
  assign async_hold_n = reset_n & ~supply_below_poweron & reset_pin_n & ~scan_reset_bit;

  pulse_filter #(
    .CNT_W(FILTER_W),
    .COUNT(BROWNOUT_CYC)
  ) u_brownout_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(brownout_on),
    .level_in(supply_below_brownout),
    .level_out(brownout_seen)
  );

  // Pin width filter, used for cause logging only; the hold is asynchronous
  pulse_filter #(
    .CNT_W(FILTER_W),
    .COUNT(PIN_CYC)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(1'b1),
    .level_in(~reset_pin_n),
    .level_out(pin_seen)
  );

  // Watchdog level memory
  // Idle level is low, so clearing it in reset gives no false edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_seen_reg <= 1'b0;
    end else begin
      watchdog_seen_reg <= watchdog_expired;
    end
  end

  // One-cycle watchdog pulse
  // A level held high still yields a single pulse, never a train
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_pulse_reg <= 1'b0;
    end else begin
      watchdog_pulse_reg <= watchdog_expired & ~watchdog_seen_reg;
    end
  end

  assign sources.poweron = supply_below_poweron;
  assign sources.pin = ~reset_pin_n;
  assign sources.watchdog = watchdog_pulse_reg;
  assign sources.brownout = brownout_seen;
  assign sources.scan = scan_reset_bit;
  assign any_active = |sources;

  // ==========================================================================
  // Port hold
  // Ports follow sources
  always_ff @(posedge ref_clk or negedge async_hold_n) begin
    if (!async_hold_n) begin
      port_reset <= 1'b1;
    end else begin
      port_reset <= any_active;
    end
  end

  // ==========================================================================
  // Delay selection
  logic [DELAY_W-1:0] delay_load;

  // Fuse-chosen time-out
  // One cycle is the floor; the counter releases when it reaches one
  always_comb begin
    case (startup_time_fuses)
      SUT_NO_DELAY: delay_load = DELAY_W'(1);
      SUT_SHORT_DELAY: delay_load = DELAY_W'(DELAY_SHORT_CYC);
      default: delay_load = DELAY_W'(DELAY_LONG_CYC);
    endcase
    // Crystal selections add an oscillator start-up allowance
    if (clock_select_fuses[0]) begin
      delay_load = delay_load + DELAY_W'(OSC_CYC);
    end
  end

  // ==========================================================================
  // Internal reset sequencer
  reset_state_t state_reg;
  reset_state_t state_next;
  logic [DELAY_W-1:0] delay_reg;
  logic [DELAY_W-1:0] delay_next;
  logic release_now;

  always_comb begin
    state_next = state_reg;
    delay_next = delay_reg;
    release_now = 1'b0;
    case (state_reg)
      ST_HOLD: begin
        if (!any_active) begin
          state_next = ST_DELAY;
          delay_next = delay_load;
        end
      end
      ST_DELAY: begin
        if (any_active) begin
          state_next = ST_HOLD;
        end else if (delay_reg <= DELAY_W'(1)) begin
          state_next = ST_RUN;
          release_now = 1'b1;
        end else begin
          delay_next = delay_reg - DELAY_W'(1);
        end
      end
      ST_RUN: begin
        if (any_active) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge async_hold_n) begin
    if (!async_hold_n) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk or negedge async_hold_n) begin
    if (!async_hold_n) begin
      delay_reg <= '0;
    end else begin
      delay_reg <= delay_next;
    end
  end

  always_ff @(posedge ref_clk or negedge async_hold_n) begin
    if (!async_hold_n) begin
      periph_reset_n <= 1'b0;
    end else if (any_active) begin
      periph_reset_n <= 1'b0;
    end else if (release_now) begin
      periph_reset_n <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge async_hold_n) begin
    if (!async_hold_n) begin
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= release_now;
    end
  end

  // ==========================================================================
  // Brown-out detector control
  // Enable follows fuse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_enable <= 1'b0;
    end else begin
      brownout_enable <= brownout_on;
    end
  end

  // Trip level select
  // Code 011 picks the lowest level, 000 the highest
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brownout_trip_level <= 2'h0;
    end else begin
      brownout_trip_level <= ~brownout_level_fuses[1:0];
    end
  end

  // ==========================================================================
  // Reset cause flags
  // Kept on reset_n only, so a stretched internal reset never wipes the cause
  cause_flags_t flags_reg;
  cause_flags_t flags_next;
  logic flags_write;

  assign flags_write = reg_write && (reg_addr == RESET_CAUSE_FLAGS_ADDR);

  always_comb begin
    flags_next = flags_reg;
    if (flags_write) begin
      // Only zeros clear; writing one leaves a flag as it is
      flags_next = cause_flags_t'(flags_reg & reg_wdata & CAUSE_FLAGS_MASK);
    end
    if (pin_seen) begin
      flags_next.pin_reset_flag = 1'b1;
    end
    if (sources.brownout) begin
      flags_next.brownout_reset_flag = 1'b1;
    end
    if (sources.watchdog) begin
      flags_next.watchdog_reset_flag = 1'b1;
    end
    if (sources.scan) begin
      flags_next.scan_reset_flag = 1'b1;
    end
    // Power-on comes last so it wins over every other set
    // Power-on clears others
    if (sources.poweron) begin
      flags_next.scan_reset_flag = 1'b0;
      flags_next.watchdog_reset_flag = 1'b0;
      flags_next.brownout_reset_flag = 1'b0;
      flags_next.pin_reset_flag = 1'b0;
    end
    if (sources.poweron) begin
      flags_next.poweron_reset_flag = 1'b1;
    end
    flags_next.reserved = 3'h0;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= cause_flags_t'(CAUSE_FLAGS_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // Register read port
  logic [DATA_W-1:0] live_status;
  logic [DATA_W-1:0] fuse_readback;

  assign live_status = {state_reg, sources};
  assign fuse_readback = {1'b0, brownout_level_fuses, clock_select_fuses[3:2],
                          startup_time_fuses};

  // Data stand for one cycle only, then fall back to zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_read) begin
      case (reg_addr)
        RESET_CAUSE_FLAGS_ADDR: reg_rdata <= flags_reg;
        RESET_LIVE_STATUS_ADDR: reg_rdata <= live_status;
        FUSE_READBACK_ADDR: reg_rdata <= fuse_readback;
        default: reg_rdata <= READ_ZERO;
      endcase
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

endmodule // system_reset_controller

// file: test/reset_ctrl_checker.sv
// Purpose: Port-level checks of the reset controller
// Assumes: Fuses change only while reset_n is low; checked block is bound in the bench top
// Notes: Brown-out filter depth is a literal 4 to match the bench parameter
`timescale 1ns/1ps
module reset_ctrl_checker
  import reset_ctrl_pkg::*;
#(
  parameter int DELAY_SHORT_CYC = 4,
  parameter int DELAY_LONG_CYC = 6,
  parameter int OSC_CYC = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic supply_below_poweron,
  input wire logic reset_pin_n,
  input wire logic watchdog_expired,
  input wire logic supply_below_brownout,
  input wire logic scan_reset_bit,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic port_reset,
  input wire logic periph_reset_n,
  input wire logic vector_fetch,
  input wire logic brownout_enable,
  input wire logic [1:0] brownout_trip_level
);
  // ==========================================================================
  // Delay length seen at the ports
  int dly_cnt;
  int dly_exp;
  assign dly_exp = ((startup_time_fuses == 2'h0) ? 1 :
    (startup_time_fuses == 2'h1) ? DELAY_SHORT_CYC : DELAY_LONG_CYC) +
    (clock_select_fuses[0] ? OSC_CYC : 0);
  // Counts only the stretch, so a source during delay restarts it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_cnt <= 0;
    end else if (port_reset || periph_reset_n) begin
      dly_cnt <= 0;
    end else begin
      dly_cnt <= dly_cnt + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Properties
  property p_async_hold;
    (supply_below_poweron || !reset_pin_n || scan_reset_bit) |-> port_reset && !periph_reset_n;
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("async source not holding");
  property p_delay_len;
    $rose(periph_reset_n) |-> dly_cnt == dly_exp;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("reset stretch wrong length");
  property p_release_free;
    $rose(periph_reset_n) |-> !$past(port_reset) && !$past(scan_reset_bit);
  endproperty
  a_release_free: assert property (p_release_free) else $error("release while held");
  property p_fetch;
    $rose(periph_reset_n) |-> vector_fetch ##1 !vector_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");
  property p_fetch_run;
    vector_fetch |-> periph_reset_n && !$past(periph_reset_n);
  endproperty
  a_fetch_run: assert property (p_fetch_run) else $error("fetch without release");
  property p_wd_hold;
    $rose(watchdog_expired) |-> ##[1:3] (port_reset && !periph_reset_n);
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("watchdog gave no reset");
  property p_bod_hold;
    (brownout_enable && supply_below_brownout) [*4] |-> ##[1:4] (port_reset && !periph_reset_n);
  endproperty
  a_bod_hold: assert property (p_bod_hold) else $error("brown-out gave no reset");
  property p_bod_en;
    $past(reset_n) |-> brownout_enable == !brownout_level_fuses[2];
  endproperty
  a_bod_en: assert property (p_bod_en) else $error("brown-out enable wrong");
  property p_bod_lvl;
    $past(reset_n) && brownout_enable |-> brownout_trip_level == ~brownout_level_fuses[1:0];
  endproperty
  a_bod_lvl: assert property (p_bod_lvl) else $error("trip level wrong");
endmodule // reset_ctrl_checker

// file: test/source_model.sv
// Purpose: Detector and reset pin model driving the reset sources
// Assumes: Driven on rising edges by non-blocking assignment
// Notes: One source at a time, which keeps each cause flag unambiguous
`timescale 1ns/1ps
module source_model (
  input wire logic ref_clk,
  output logic supply_below_poweron,
  output logic reset_pin_n,
  output logic watchdog_expired,
  output logic supply_below_brownout,
  output logic scan_reset_bit
);
  initial begin
    supply_below_poweron = 1'b0;
    reset_pin_n = 1'b1;
    watchdog_expired = 1'b0;
    supply_below_brownout = 1'b0;
    scan_reset_bit = 1'b0;
  end
  // ==========================================================================
  // Five sources, by flag index
  task automatic pulse(input int src, input int n);
    @(posedge ref_clk);
    case (src)
      0: supply_below_poweron <= 1'b1;
      1: reset_pin_n <= 1'b0;
      2: supply_below_brownout <= 1'b1;
      3: watchdog_expired <= 1'b1;
      default: scan_reset_bit <= 1'b1;
    endcase
    repeat (n) @(posedge ref_clk);
    supply_below_poweron <= 1'b0;
    reset_pin_n <= 1'b1;
    watchdog_expired <= 1'b0;
    supply_below_brownout <= 1'b0;
    scan_reset_bit <= 1'b0;
  endtask
endmodule // source_model

// file: test/system_reset_controller_tb_top.sv
// Purpose: Directed register and reset-source tests of the controller
// Assumes: Fuses start at short delay and the lowest brown-out level
// Notes: Fuses move only inside a mid-run reset, so every delay choice is reached
`timescale 1ns/1ps
module system_reset_controller_tb_top;
  import reset_ctrl_pkg::*;
  logic ref_clk, reset_n, sb_por, pin_n, wd, sb_bod, scan;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_write, reg_read, port_reset, periph_reset_n, vector_fetch, bod_en;
  logic [1:0] trip;
  logic [2:0] bod_fuse;
  logic [1:0] sut_fuse;
  logic [3:0] clock_select_fuses_fuse;
  logic [7:0] fetch_cnt = 8'h00;
  logic [7:0] fetch_exp = 8'h00;
  int error_cnt = 0;
  int checks_done = 0;
  system_reset_controller #(.DELAY_SHORT_CYC(4), .DELAY_LONG_CYC(6), .OSC_CYC(2),
    .PIN_CYC(3), .BROWNOUT_CYC(4)) system_reset_controller_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .supply_below_poweron(sb_por),
    .reset_pin_n(pin_n), .watchdog_expired(wd), .supply_below_brownout(sb_bod),
    .scan_reset_bit(scan), .brownout_level_fuses(bod_fuse), .startup_time_fuses(sut_fuse),
    .clock_select_fuses(clock_select_fuses_fuse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .port_reset(port_reset), .periph_reset_n(periph_reset_n),
    .vector_fetch(vector_fetch), .brownout_enable(bod_en), .brownout_trip_level(trip));
  source_model source_model_i (.ref_clk(ref_clk), .supply_below_poweron(sb_por),
    .reset_pin_n(pin_n), .watchdog_expired(wd), .supply_below_brownout(sb_bod),
    .scan_reset_bit(scan));
  // Counts fetch pulses at the edge that ends them
  always @(posedge ref_clk) begin
    if (vector_fetch === 1'b1) begin
      fetch_cnt <= fetch_cnt + 8'h01;
    end
  end
  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Bounded wait; watchdog and brown-out act a few edges late
  task automatic wait_run();
    int i;
    i = 0;
    fetch_exp = fetch_exp + 8'h01;
    repeat (3) @(posedge ref_clk);
    while (periph_reset_n !== 1'b1 && i < 200) begin
      @(posedge ref_clk);
      i++;
    end
    chk({7'h00, periph_reset_n}, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(fetch_cnt, fetch_exp);
  endtask
  // Mid-run reset; fuses move only while reset_n is low
  task automatic fuse_reset(input logic [2:0] b, input logic [1:0] s, input logic [3:0] c);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    bod_fuse <= b;
    sut_fuse <= s;
    clock_select_fuses_fuse <= c;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_run();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog, tests
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    bod_fuse = 3'h3;
    sut_fuse = 2'h1;
    clock_select_fuses_fuse = 4'h0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_run();
    rd(2'h0, 8'h01);
    rd(2'h1, 8'h80);
    rd(2'h2, 8'h31);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h31);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    $display("test registers done");
    for (int i = 1; i < 5; i++) begin
      wr(2'h0, 8'h00);
      source_model_i.pulse(i, (i == 3) ? 1 : 6);
      wait_run();
      rd(2'h0, 8'h01 << i);
    end
    $display("test sources done");
    wr(2'h0, 8'h00);
    source_model_i.pulse(2, 2);
    repeat (6) @(posedge ref_clk);
    chk({7'h00, periph_reset_n}, 8'h01);
    rd(2'h0, 8'h00);
    $display("test short dip done");
    source_model_i.pulse(1, 6);
    wait_run();
    source_model_i.pulse(3, 1);
    wait_run();
    rd(2'h0, 8'h0A);
    source_model_i.pulse(0, 6);
    wait_run();
    rd(2'h0, 8'h01);
    $display("test sticky and power-on done");
    fuse_reset(3'h7, 2'h2, 4'hD);
    rd(2'h2, 8'h7E);
    source_model_i.pulse(2, 6);
    repeat (4) @(posedge ref_clk);
    chk({7'h00, periph_reset_n}, 8'h01);
    chk({7'h00, bod_en}, 8'h00);
    rd(2'h0, 8'h01);
    fuse_reset(3'h0, 2'h0, 4'h4);
    rd(2'h2, 8'h04);
    chk({6'h00, trip}, 8'h03);
    source_model_i.pulse(2, 6);
    wait_run();
    rd(2'h0, 8'h05);
    wr(2'h0, 8'h00);
    source_model_i.pulse(1, 2);
    wait_run();
    rd(2'h0, 8'h00);
    $display("test fuses done");
    close_out();
  end
endmodule // system_reset_controller_tb_top

bind system_reset_controller reset_ctrl_checker #(.DELAY_SHORT_CYC(DELAY_SHORT_CYC),
  .DELAY_LONG_CYC(DELAY_LONG_CYC), .OSC_CYC(OSC_CYC)) reset_ctrl_checker_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .supply_below_poweron(supply_below_poweron),
  .reset_pin_n(reset_pin_n), .watchdog_expired(watchdog_expired),
  .supply_below_brownout(supply_below_brownout), .scan_reset_bit(scan_reset_bit),
  .brownout_level_fuses(brownout_level_fuses), .startup_time_fuses(startup_time_fuses),
  .clock_select_fuses(clock_select_fuses), .port_reset(port_reset),
  .periph_reset_n(periph_reset_n), .vector_fetch(vector_fetch),
  .brownout_enable(brownout_enable), .brownout_trip_level(brownout_trip_level));
